// ### rtl/sllfe_front_end.sv
// Serial loader link front end: auto-baud async port, mode-3 sync slave, packet check and answer.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Runs from the single crystal-derived clock; rates scale with it.
// - Both ports feed one shared packet checker and answer path.
// - Port locked until reset is the first to select (sync) or complete detection (async); other ignored.
// - Async characters: eight data bits, no parity, one stop bit.
// - Async divisor never below sixteen system clocks per bit.
// - Sync pulse train is timed and sets receive and transmit divisor.
// - After detection, one 0xcc byte is sent at the detected rate.
// - Sync port uses phase one, polarity one framing.
// - Host is master and clocks the sync port; no detection here.
// - Each packet answered with 0xcc if good, else 0x33.
// - First packet byte is total size including size and checksum.
// - Second byte equals eight-bit sum of data bytes only.
// - Leading zero bytes skipped; first non-zero starts a packet.
module sllfe_front_end #(
    parameter int SYNC_TIMEOUT = sllfe_pkg::SYNC_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Async port
    input wire logic async_rx,
    output logic async_tx,
    // Sync slave port
    input wire logic sync_clk,
    input wire logic sync_sel_n,
    input wire logic sync_mosi,
    output logic sync_miso,
    output logic sync_miso_oe,
    // Status
    output logic [1:0] port_locked,
    output logic baud_locked,
    output logic [15:0] baud_divisor,
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    output logic [7:0] pkt_size,
    output logic pkt_done,
    output logic pkt_good
);
    // Idle timer is sixteen bits and saturates
    if (SYNC_TIMEOUT < 16 || SYNC_TIMEOUT > 65535) begin : bad_timeout_g
        $error("SYNC_TIMEOUT out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] rx_s_q, sck_s_q, sel_s_q, mosi_s_q;
    logic rxl_q, sckl_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_s_q <= 2'h3;
            sck_s_q <= 2'h3;
            sel_s_q <= 2'h3;
            mosi_s_q <= 2'h0;
            rxl_q <= 1'b1;
            sckl_q <= 1'b1;
        end else begin
            rx_s_q <= {rx_s_q[0], async_rx};
            sck_s_q <= {sck_s_q[0], sync_clk};
            sel_s_q <= {sel_s_q[0], sync_sel_n};
            mosi_s_q <= {mosi_s_q[0], sync_mosi};
            rxl_q <= rx_s_q[1];
            sckl_q <= sck_s_q[1];
        end
    end
    wire rx = rx_s_q[1];
    wire rx_edge = rx ^ rxl_q;
    wire rx_fall = rxl_q && !rx;
    wire sel = !sel_s_q[1];
    wire sck_rise = sel && sck_s_q[1] && !sckl_q;
    wire sck_fall = sel && !sck_s_q[1] && sckl_q;

    ////////////////////////////////////////////////////////////////////////////
    // Port lock and auto-baud
    sllfe_pkg::sllfe_port_t port_q, port_d;
    logic [15:0] div_q, div_d, tmr_q, tmr_d, span_q, span_d;
    logic [3:0] edges_q, edges_d;
    logic locked_q, locked_d;
    logic ack_req;
    logic async_byte_v, sync_byte_v;
    logic [7:0] async_byte, sync_byte;
    // Pattern has ten falling edges; the last nine span sixteen bit times
    always_comb begin
        port_d = port_q;
        div_d = div_q;
        tmr_d = (tmr_q == 16'hffff) ? tmr_q : tmr_q + 16'h0001;
        span_d = (span_q == 16'hffff) ? span_q : span_q + 16'h0001;
        edges_d = edges_q;
        locked_d = locked_q;
        ack_req = 1'b0;
        if (port_q == sllfe_pkg::SLLFE_PORT_NONE && sel) begin
            port_d = sllfe_pkg::SLLFE_PORT_SYNC;
        end
        if (!locked_q && port_q != sllfe_pkg::SLLFE_PORT_SYNC) begin
            if (tmr_q >= 16'(SYNC_TIMEOUT)) begin
                edges_d = 4'h0;
            end
            if (rx_edge) begin
                tmr_d = 16'h0000;
            end
            if (rx_fall) begin
                if (edges_d == 4'(sllfe_pkg::SYNC_EDGES)) begin
                    edges_d = 4'h0;
                    // Lock on the last falling edge, so no later pattern edge looks like a start bit
                    if ({4'h0, span_q[15:4]} >= sllfe_pkg::DIV_MIN) begin
                        div_d = {4'h0, span_q[15:4]};
                        locked_d = 1'b1;
                        ack_req = 1'b1;
                        port_d = sllfe_pkg::SLLFE_PORT_ASYNC;
                    end
                end else begin
                    if (edges_d == 4'h1) span_d = 16'h0001;
                    edges_d = edges_d + 4'h1;
                end
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port_q <= sllfe_pkg::SLLFE_PORT_NONE;
            div_q <= sllfe_pkg::DIV_RESET;
            tmr_q <= 16'h0000;
            edges_q <= 4'h0;
            locked_q <= 1'b0;
            span_q <= 16'h0000;
        end else begin
            port_q <= port_d;
            div_q <= div_d;
            tmr_q <= tmr_d;
            edges_q <= edges_d;
            locked_q <= locked_d;
            span_q <= span_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Async receiver and transmitter
    logic [15:0] rcnt_q, tcnt_q;
    logic [3:0] rbit_q, tbit_q;
    logic [7:0] rsh_q;
    logic rbusy_q, tbusy_q;
    logic [9:0] tsh_q;
    logic [7:0] tx_pend_q;
    logic tx_req_q;
    logic ans_v;
    logic [7:0] ans_b;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rcnt_q <= 16'h0000;
            rbit_q <= 4'h0;
            rsh_q <= 8'h00;
            rbusy_q <= 1'b0;
            async_byte_v <= 1'b0;
            async_byte <= 8'h00;
            tcnt_q <= 16'h0000;
            tbit_q <= 4'h0;
            tsh_q <= 10'h3ff;
            tbusy_q <= 1'b0;
            tx_req_q <= 1'b0;
            tx_pend_q <= 8'h00;
        end else begin
            async_byte_v <= 1'b0;
            if (locked_q && port_q == sllfe_pkg::SLLFE_PORT_ASYNC) begin
                if (!rbusy_q) begin
                    if (rx_fall) begin
                        rbusy_q <= 1'b1;
                        rcnt_q <= {1'b0, div_q[15:1]};
                        rbit_q <= 4'h0;
                    end
                end else if (rcnt_q == 16'h0000) begin
                    rcnt_q <= div_q - 16'h0001;
                    rbit_q <= rbit_q + 4'h1;
                    if (rbit_q == 4'h0 && rx) begin
                        rbusy_q <= 1'b0;
                    end else if (rbit_q >= 4'h1 && rbit_q <= 4'h8) begin
                        rsh_q <= {rx, rsh_q[7:1]};
                    end else if (rbit_q == 4'h9) begin
                        rbusy_q <= 1'b0;
                        async_byte_v <= rx;
                        async_byte <= rsh_q;
                    end
                end else begin
                    rcnt_q <= rcnt_q - 16'h0001;
                end
            end
            if (!tbusy_q && tx_req_q && locked_q) begin
                tbusy_q <= 1'b1;
                tx_req_q <= 1'b0;
                tsh_q <= {1'b1, tx_pend_q, 1'b0};
                tbit_q <= 4'h0;
                tcnt_q <= div_q - 16'h0001;
            end else if (tbusy_q) begin
                if (tcnt_q == 16'h0000) begin
                    tcnt_q <= div_q - 16'h0001;
                    tsh_q <= {1'b1, tsh_q[9:1]};
                    tbit_q <= tbit_q + 4'h1;
                    if (tbit_q == 4'h9) tbusy_q <= 1'b0;
                end else begin
                    tcnt_q <= tcnt_q - 16'h0001;
                end
            end
            // A new request outranks the hand-off in the same cycle
            if (ack_req || (ans_v && port_q == sllfe_pkg::SLLFE_PORT_ASYNC)) begin
                tx_req_q <= 1'b1;
                tx_pend_q <= ack_req ? sllfe_pkg::ACK_BYTE : ans_b;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync slave, mode three: drive on falling, sample on rising
    logic [7:0] ssh_q, sout_q, snext_q;
    logic [2:0] scnt_q;
    logic miso_q;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ssh_q <= 8'h00;
            sout_q <= 8'h00;
            snext_q <= 8'h00;
            scnt_q <= 3'h0;
            miso_q <= 1'b0;
            sync_byte_v <= 1'b0;
            sync_byte <= 8'h00;
        end else begin
            sync_byte_v <= 1'b0;
            if (!sel || port_q == sllfe_pkg::SLLFE_PORT_ASYNC) begin
                scnt_q <= 3'h0;
            end else begin
                if (sck_fall) begin
                    if (scnt_q == 3'h0) begin
                        miso_q <= snext_q[7];
                        sout_q <= {snext_q[6:0], 1'b0};
                        snext_q <= 8'h00; // Zero padding after the answer
                    end else begin
                        miso_q <= sout_q[7];
                        sout_q <= {sout_q[6:0], 1'b0};
                    end
                end
                if (sck_rise) begin
                    ssh_q <= {ssh_q[6:0], mosi_s_q[1]};
                    scnt_q <= scnt_q + 3'h1;
                    if (scnt_q == 3'h7) begin
                        sync_byte_v <= 1'b1;
                        sync_byte <= {ssh_q[6:0], mosi_s_q[1]};
                    end
                end
            end
            // Loaded answer wins over the padding clear
            if (ans_v && port_q == sllfe_pkg::SLLFE_PORT_SYNC) snext_q <= ans_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared packet checker
    typedef enum logic [1:0] {PK_IDLE, PK_SUM, PK_DATA} sllfe_pk_t;
    sllfe_pk_t pk_q, pk_d;
    logic [7:0] size_q, size_d, sum_q, sum_d, ck_q, ck_d, left_q, left_d;
    sllfe_pkg::sllfe_byte_t in_b;
    sllfe_pkg::sllfe_pkt_t res;
    always_comb begin
        in_b.valid = (port_q == sllfe_pkg::SLLFE_PORT_SYNC) ? sync_byte_v : async_byte_v;
        in_b.data = (port_q == sllfe_pkg::SLLFE_PORT_SYNC) ? sync_byte : async_byte;
        pk_d = pk_q;
        size_d = size_q;
        sum_d = sum_q;
        ck_d = ck_q;
        left_d = left_q;
        res = '0;
        if (in_b.valid) begin
            unique case (pk_q)
                PK_IDLE: begin
                    if (in_b.data != 8'h00) begin
                        size_d = in_b.data;
                        left_d = in_b.data - 8'h02;
                        sum_d = 8'h00;
                        pk_d = PK_SUM;
                        if (in_b.data < 8'h02) begin
                            pk_d = PK_IDLE;
                            res = '{valid: 1'b1, good: 1'b0, size: in_b.data};
                        end
                    end
                end
                PK_SUM: begin
                    ck_d = in_b.data;
                    pk_d = PK_DATA;
                    if (left_q == 8'h00) begin
                        pk_d = PK_IDLE;
                        res = '{valid: 1'b1, good: (in_b.data == 8'h00), size: size_q};
                    end
                end
                PK_DATA: begin
                    sum_d = sum_q + in_b.data;
                    left_d = left_q - 8'h01;
                    if (left_q == 8'h01) begin
                        pk_d = PK_IDLE;
                        res = '{valid: 1'b1, good: (sum_q + in_b.data == ck_q), size: size_q};
                    end
                end
            endcase
        end
        ans_v = res.valid;
        ans_b = res.good ? sllfe_pkg::ACK_BYTE : sllfe_pkg::NAK_BYTE;
    end
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pk_q <= PK_IDLE;
            size_q <= 8'h00;
            sum_q <= 8'h00;
            ck_q <= 8'h00;
            left_q <= 8'h00;
            pkt_done <= 1'b0;
            pkt_good <= 1'b0;
            pkt_size <= 8'h00;
            rx_byte <= 8'h00;
            rx_byte_valid <= 1'b0;
        end else begin
            pk_q <= pk_d;
            size_q <= size_d;
            sum_q <= sum_d;
            ck_q <= ck_d;
            left_q <= left_d;
            pkt_done <= res.valid;
            if (res.valid) pkt_good <= res.good;
            if (res.valid) pkt_size <= res.size;
            rx_byte_valid <= in_b.valid;
            if (in_b.valid) rx_byte <= in_b.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            async_tx <= 1'b1;
            sync_miso <= 1'b0;
            sync_miso_oe <= 1'b0;
            port_locked <= 2'h0;
            baud_locked <= 1'b0;
            baud_divisor <= sllfe_pkg::DIV_RESET;
        end else begin
            async_tx <= tbusy_q ? tsh_q[0] : 1'b1;
            sync_miso <= miso_q;
            sync_miso_oe <= sel && port_q == sllfe_pkg::SLLFE_PORT_SYNC;
            port_locked <= port_q;
            baud_locked <= locked_q;
            baud_divisor <= div_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    port_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        port_q != sllfe_pkg::SLLFE_PORT_NONE |=> port_q == $past(port_q)) else $error("port changed");
    div_floor_a: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(locked_q) |-> div_q >= sllfe_pkg::DIV_MIN) else $error("divisor too small");
    tx_silent_a: assert property (@(posedge sys_clk) disable iff (srst)
        !locked_q |=> async_tx) else $error("tx before lock");
    ack_queue_a: assert property (@(posedge sys_clk) disable iff (srst)
        ack_req |=> tx_req_q && tx_pend_q == sllfe_pkg::ACK_BYTE) else $error("no ack");
    answer_code_a: assert property (@(posedge sys_clk) disable iff (srst)
        ans_v && port_q == sllfe_pkg::SLLFE_PORT_ASYNC |=> tx_req_q && tx_pend_q == $past(ans_b))
        else $error("answer not queued");
    zero_skip_a: assert property (@(posedge sys_clk) disable iff (srst)
        pk_q == PK_IDLE && in_b.valid && in_b.data == 8'h00 |=> pk_q == PK_IDLE) else $error("zero started");
endmodule

// ### rtl/sllfe_pkg.sv
// Package for the serial loader link front end: constants and carrier types.
package sllfe_pkg;
    localparam logic [7:0] SYNC_BYTE = 8'h55;
    localparam logic [7:0] ACK_BYTE = 8'hcc;
    localparam logic [7:0] NAK_BYTE = 8'h33;
    localparam int SYNC_EDGES = 9;
    localparam int UART_OVERSAMPLE = 16;
    localparam int SYSCLK_MHZ = 250;
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_MIN = 16'h0010;
    localparam int SYNC_TIMEOUT_CYC = 65535;

    typedef enum logic [1:0] {
        SLLFE_PORT_NONE,
        SLLFE_PORT_ASYNC,
        SLLFE_PORT_SYNC
    } sllfe_port_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } sllfe_byte_t;

    typedef struct packed {
        logic valid;
        logic good;
        logic [7:0] size;
    } sllfe_pkt_t;
endpackage

// ### test/sllfe_host_model.sv
// Host model: async sender and receiver, mode-3 sync master.
`timescale 1ns/1ps

module sllfe_host_model (
    // Clock
    input wire logic sys_clk,
    // Async pins
    output logic async_rx,
    input wire logic async_tx,
    // Sync pins
    output logic sync_clk,
    output logic sync_sel_n,
    output logic sync_mosi,
    input wire logic sync_miso,
    input wire logic sync_miso_oe
);
    logic last_miso;

    initial begin
        async_rx = 1'b1; // Line idles high
        sync_clk = 1'b1; // Clock idles high
        sync_sel_n = 1'b1;
        sync_mosi = 1'b0;
        last_miso = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Start, eight bits LSB first, one stop, no parity
    task automatic uart_send(input logic [7:0] b, input int p);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            async_rx <= f[i];
            tick(p);
        end
    endtask

    // Bit period is the caller's; legal hosts use 16 clocks or more
    task automatic uart_sync(input int p);
        uart_send(sllfe_pkg::SYNC_BYTE, p);
        uart_send(sllfe_pkg::SYNC_BYTE, p);
    endtask

    // Bounded wait for a start bit, then mid-bit sampling
    task automatic uart_recv(input int p, input int lim, output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (async_tx !== 1'b0 && n < lim) begin
            tick(1);
            n++;
        end
        if (n < lim) begin
            tick(p / 2);
            ok = (async_tx === 1'b0);
            for (int i = 0; i < 8; i++) begin
                tick(p);
                b[i] = async_tx;
            end
            tick(p);
            ok = ok && (async_tx === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Master clock of 12 system clocks, MSB first, sample before rise
    task automatic spi_xfer(input logic [7:0] t, output logic [7:0] r);
        sync_sel_n <= 1'b0;
        tick(6);
        for (int i = 7; i >= 0; i--) begin
            sync_clk <= 1'b0;
            sync_mosi <= t[i];
            tick(6);
            // Undriven miso must not read as a clean value
            r[i] = sync_miso_oe ? sync_miso : ~last_miso;
            last_miso = r[i];
            sync_clk <= 1'b1;
            tick(6);
        end
        sync_sel_n <= 1'b1;
        sync_mosi <= ~sync_mosi;
        tick(12);
    endtask
endmodule

// ### test/testbench.sv
// Self-checking testbench for the serial loader link front end.
`timescale 1ns/1ps

module testbench;
    localparam int TOUT = 2000;
    localparam int MAX_CYC = 90000;
    logic sys_clk;
    logic srst;
    logic async_rx, async_tx, sync_clk, sync_sel_n, sync_mosi, sync_miso, sync_miso_oe;
    logic [1:0] port_locked;
    logic baud_locked, rx_byte_valid, pkt_done, pkt_good;
    logic [15:0] baud_divisor;
    logic [7:0] rx_byte, pkt_size;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int nbytes = 0;
    logic tx_early = 1'b0;
    logic seen = 1'b0;
    logic seen_good, seen_bad_size;
    logic [7:0] seen_last;

    always #2 sys_clk = ~sys_clk;

    sllfe_front_end #(.SYNC_TIMEOUT(TOUT)) DUT (.sys_clk(sys_clk), .srst(srst), .async_rx(async_rx),
        .async_tx(async_tx), .sync_clk(sync_clk), .sync_sel_n(sync_sel_n), .sync_mosi(sync_mosi),
        .sync_miso(sync_miso), .sync_miso_oe(sync_miso_oe), .port_locked(port_locked),
        .baud_locked(baud_locked), .baud_divisor(baud_divisor), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .pkt_size(pkt_size), .pkt_done(pkt_done), .pkt_good(pkt_good));

    sllfe_host_model host (.sys_clk(sys_clk), .async_rx(async_rx), .async_tx(async_tx),
        .sync_clk(sync_clk), .sync_sel_n(sync_sel_n), .sync_mosi(sync_mosi),
        .sync_miso(sync_miso), .sync_miso_oe(sync_miso_oe));

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor; a silent transmitter before lock is tracked all run long
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rx_byte_valid === 1'b1)
            nbytes <= nbytes + 1;
        if (srst === 1'b0 && baud_locked !== 1'b1 && async_tx !== 1'b1)
            tx_early <= 1'b1;
        if (pkt_done === 1'b1) begin
            seen <= 1'b1;
            seen_good <= pkt_good;
            seen_bad_size <= (pkt_size !== 8'h05);
            seen_last <= rx_byte;
        end
        if (cyc == MAX_CYC) begin
            err_count = err_count + 1;
            print_verdict();
        end
    end

    function automatic logic [7:0] answer_of(input logic bad);
        return bad ? sllfe_pkg::NAK_BYTE : sllfe_pkg::ACK_BYTE;
    endfunction

    // Leading zero, size 5, checksum, three data bytes; then fetch the answer
    task automatic send_pkt(input logic on_sync, input int p, input logic bad);
        logic [7:0] pkt[6];
        logic [7:0] d0, d1, d2, r, a;
        logic ok;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        pkt = '{8'h00, 8'h05, (d0 + d1 + d2) ^ {7'h00, bad}, d0, d1, d2};
        seen = 1'b0;
        a = 8'h00;
        ok = 1'b1;
        if (on_sync) begin
            for (int i = 0; i < 6; i++)
                host.spi_xfer(pkt[i], r);
            for (int i = 0; i < 4 && a == 8'h00; i++)
                host.spi_xfer(8'h00, a);
        end else begin
            fork
                for (int i = 0; i < 6; i++)
                    host.uart_send(pkt[i], p);
                host.uart_recv(p, 80 * p, a, ok);
            join
        end
        check(seen === 1'b1 && seen_good === !bad, "packet verdict");
        check(seen_bad_size === 1'b0, "packet size");
        check(ok === 1'b1 && a === answer_of(bad), "packet answer");
        check(seen_last === d2, "last data byte");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a;
        logic ok;
        int p;
        int n0;
        sys_clk = 1'b0;
        srst = 1'b1;
        void'($urandom(30));
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        host.tick(4);
        check(async_tx === 1'b1 && port_locked === 2'h0 && baud_locked === 1'b0, "reset state");
        check(sync_miso_oe === 1'b0, "miso driven at reset");
        // Too fast a sync pattern is refused, then hunting resumes
        host.uart_sync(8);
        host.tick(20);
        check(baud_locked === 1'b0 && tx_early === 1'b0, "fast sync accepted");
        host.tick(TOUT + 100);
        p = 32 + int'($urandom % 33);
        ok = 1'b0;
        for (int t = 0; t < 2 && !ok; t++) begin
            // Resend when no answer comes back
            fork
                host.uart_sync(p);
                host.uart_recv(p, 60 * p, a, ok);
            join
        end
        check(ok === 1'b1 && a === sllfe_pkg::ACK_BYTE, "sync answer");
        check(baud_locked === 1'b1 && port_locked === 2'h1, "async lock");
        check(baud_divisor >= sllfe_pkg::DIV_MIN && baud_divisor === 16'(p), "divisor high");
        check(baud_divisor + p / 4 >= p && tx_early === 1'b0, "divisor low");
        for (int k = 0; k < 3; k++)
            send_pkt(1'b0, p, k == 1);
        n0 = nbytes;
        host.spi_xfer(8'h5a, a);
        host.tick(10);
        check(nbytes == n0 && port_locked === 2'h1 && sync_miso_oe === 1'b0, "sync port heard");
        // Second session starts on the sync port
        srst <= 1'b1;
        host.tick(8);
        srst <= 1'b0;
        host.tick(4);
        send_pkt(1'b1, p, 1'b0);
        send_pkt(1'b1, p, 1'b1);
        check(port_locked === 2'h2, "sync lock");
        host.uart_sync(p);
        host.tick(40 * p);
        check(port_locked === 2'h2 && baud_locked === 1'b0 && tx_early === 1'b0, "async heard");
        print_verdict();
    end
endmodule
